// ===== tb/ctw_console_model.sv
module ctw_console_model
  import ctw_pkg::*;
(
  input  wire logic       ref_clk,
  output logic            key_press,
  output logic [5:0]      key_code,
  output logic            kbd_request_btn,
  output logic            kbd_release_btn,
  output logic            online_btn
);
  timeunit 1ns;
  timeprecision 100ps;

  // Keys and buttons rest released
  initial begin
    key_press = 1'b0;
    key_code = 6'h2A;
    kbd_request_btn = 1'b0;
    kbd_release_btn = 1'b0;
    online_btn = 1'b0;
  end

  // Key held for a chosen time; a released code line shows the inverse code
  task automatic press_key(input logic [5:0] code, input int hold);
    @(posedge ref_clk);
    key_code <= code;
    repeat (2) @(posedge ref_clk);
    key_press <= 1'b1;
    repeat (hold) @(posedge ref_clk);
    key_press <= 1'b0;
    repeat (2) @(posedge ref_clk);
    key_code <= ~code;
    repeat (6) @(posedge ref_clk);
  endtask : press_key

  // Button 0 request, 1 release, 2 online/offline
  task automatic press_btn(input int which);
    @(posedge ref_clk);
    {online_btn, kbd_release_btn, kbd_request_btn} <= 3'(1 << which);
    repeat (5) @(posedge ref_clk);
    {online_btn, kbd_release_btn, kbd_request_btn} <= 3'h0;
    repeat (6) @(posedge ref_clk);
  endtask : press_btn

endmodule : ctw_console_model

// ===== tb/ctw_port_asserts.sv
`include "ctw_map.svh"

module ctw_port_asserts
  import ctw_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire ctw_instr_s  instr,
  input wire ctw_result_s result,
  input wire logic        type_fire,
  input wire logic [5:0]  type_char,
  input wire logic        kbd_active_lamp,
  input wire logic        online_lamp,
  input wire logic        contingency_irq
);
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Clocking and instruction decode
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic [5:0] sel_char;
  logic       is_wr;
  logic       is_arm;
  logic       is_rd;

  // Character picked by the selector and the three decoded opcodes
  assign sel_char = instr.mem_word[instr.char_sel*6 +: 6];
  assign is_wr    = instr.valid && (instr.opcode == `CTW_OP_WRITE_CHAR);
  assign is_arm   = instr.valid && (instr.opcode == `CTW_OP_ARM_KEYBOARD);
  assign is_rd    = instr.valid && (instr.opcode == `CTW_OP_READ_CHAR);

  // ==========================================================================
  // Sequences
  sequence s_print_start;
    result.done && (result.cc_step == 2'd2) && type_fire;
  endsequence

  sequence s_arm_ack;
    result.done && (result.cc_step == 2'd1) ##1 kbd_active_lamp;
  endsequence

  // ==========================================================================
  // Properties
  property p_write_online;
    is_wr && online_lamp |=> s_print_start ##0 (type_char == $past(sel_char));
  endproperty
  property p_write_offline;
    is_wr && !online_lamp |=> result.done && (result.cc_step == 2'd1) && !type_fire;
  endproperty
  property p_arm_lamp;
    is_arm |=> s_arm_ack;
  endproperty
  property p_read_keep;
    is_rd |=> result.ar_we && (result.ar_data[24:6] == $past(instr.ar_value[24:6]));
  endproperty
  property p_done_cause;
    result.done |-> $past(instr.valid);
  endproperty
  property p_lamp_cause;
    $rose(kbd_active_lamp) |-> $past(is_arm, 2);
  endproperty
  property p_irq_online;
    $rose(contingency_irq) |-> $past(online_lamp);
  endproperty
  property p_fire_cause;
    type_fire && online_lamp |-> $past(is_wr);
  endproperty

  a_write_online: assert property (p_write_online) else $error("online write not started");
  a_write_offline: assert property (p_write_offline) else $error("offline write not abandoned");
  a_arm_lamp: assert property (p_arm_lamp) else $error("arm did not light lamp");
  a_read_keep: assert property (p_read_keep) else $error("read altered upper bits");
  a_done_cause: assert property (p_done_cause) else $error("answer without request");
  a_lamp_cause: assert property (p_lamp_cause) else $error("lamp lit without arm");
  a_irq_online: assert property (p_irq_online) else $error("interrupt raised offline");
  a_fire_cause: assert property (p_fire_cause) else $error("online print without write");

endmodule : ctw_port_asserts

// ===== tb/ctw_port_test.sv
`include "ctw_map.svh"

module ctw_port_test
  import ctw_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================================================
  // Signals and notes
  localparam int          PC     = 20;
  localparam ctw_result_s R_SKIP = '{1'b1, 2'd2, 1'b0, 25'h0};
  localparam ctw_result_s R_NEXT = '{1'b1, 2'd1, 1'b0, 25'h0};

  logic        ref_clk, rst, reg_wr, reg_rd, rd_seen, rd_stat;
  ctw_instr_s  instr;
  ctw_result_s result;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic        key_press, kbd_request_btn, kbd_release_btn, online_btn;
  logic [5:0]  key_code, type_char, c;
  logic        type_fire, kbd_active_lamp, online_lamp, contingency_irq;
  logic [23:0] w;
  logic [24:0] ar;
  logic [1:0]  sel;
  logic [5:0]  fmt [4] = '{`CTW_CH_CR_LF, `CTW_CH_BELL, `CTW_CH_TAB, `CTW_CH_FORM_FEED};
  int          miscompares, samples_checked, seed;
  ctw_result_s exp_res_q [$];
  logic [31:0] exp_reg_q [$];
  logic [6:0]  exp_type_q [$];

  ctw_port #(.PRINT_CYCLES(PC)) i_ctw_port (.ref_clk(ref_clk), .rst(rst), .instr(instr), .result(result),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .key_press(key_press), .key_code(key_code), .kbd_request_btn(kbd_request_btn),
    .kbd_release_btn(kbd_release_btn), .online_btn(online_btn), .type_fire(type_fire), .type_char(type_char),
    .kbd_active_lamp(kbd_active_lamp), .online_lamp(online_lamp), .contingency_irq(contingency_irq));

  ctw_console_model i_ctw_console_model (.ref_clk(ref_clk), .key_press(key_press), .key_code(key_code),
    .kbd_request_btn(kbd_request_btn), .kbd_release_btn(kbd_release_btn), .online_btn(online_btn));

  // Clock
  always #2.5 ref_clk = ~ref_clk;

  // ==========================================================================
  // Comparison and verdict
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : cmp

  task automatic check_res();
    ctw_result_s e = '0;
    if (exp_res_q.size() > 0) e = exp_res_q.pop_front();
    cmp("result", 32'(e), 32'(result));
  endtask : check_res

  task automatic check_type();
    logic [6:0] e = 7'h0;
    if (exp_type_q.size() > 0) e = exp_type_q.pop_front();
    cmp("type_char", 32'(e), 32'({type_fire, type_char}));
  endtask : check_type

  task automatic check_reg();
    logic [31:0] e = 32'hFFFFFFFF;
    if (exp_reg_q.size() > 0) e = exp_reg_q.pop_front();
    cmp("reg_rdata", e, reg_rdata);
  endtask : check_reg

  // Lamps and interrupt line follow the status bits read in the same cycle
  task automatic check_lamps(input logic [31:0] e);
    cmp("lamps", 32'({|e[2:0], e[4], e[3]}), 32'({contingency_irq, kbd_active_lamp, online_lamp}));
  endtask : check_lamps

  task automatic print_verdict();
    if (exp_res_q.size() + exp_type_q.size() + exp_reg_q.size() != 0) miscompares++;
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // Outputs are matched against the oldest note of their kind
  always @(posedge ref_clk) begin
    if (result.done === 1'b1) check_res();
    if (type_fire === 1'b1) check_type();
    if (rd_seen && rd_stat && exp_reg_q.size() > 0) check_lamps(exp_reg_q[0]);
    if (rd_seen) check_reg();
    rd_seen = (reg_rd === 1'b1);
    rd_stat = (reg_addr == `CTW_OFS_STATUS);
  end

  // ==========================================================================
  // Drivers
  task automatic issue(input logic [5:0] op, input logic [1:0] s, input logic [23:0] m,
                       input logic [24:0] a, input ctw_result_s e);
    @(posedge ref_clk);
    if (e.done) exp_res_q.push_back(e);
    instr <= '{1'b1, op, s, m, a};
    @(posedge ref_clk);
    instr.valid <= 1'b0;
  endtask : issue

  task automatic reg_access(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    if (!wr) exp_reg_q.push_back(d);
    reg_addr <= a;
    reg_wdata <= wr ? d : 32'h0;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge ref_clk);
    {reg_wr, reg_rd} <= 2'b00;
  endtask : reg_access

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 32'h3753;
    {ref_clk, reg_wr, reg_rd, rd_seen, rd_stat, miscompares, samples_checked} = '0;
    instr = '0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    rst = 1'b1;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    reg_access(1'b0, `CTW_OFS_STATUS, 32'h08);
    reg_access(1'b0, 4'h2, 32'h0);
    issue(6'h03, 2'd0, 24'h0, 25'h0, '0);
    i_ctw_console_model.press_key(6'h21, 4);
    for (int i = 0; i < 5; i++) begin
      w = 24'($random(seed));
      sel = 2'(i);
      if (i < 4) w[sel*6 +: 6] = fmt[i];
      exp_type_q.push_back({1'b1, w[sel*6 +: 6]});
      reg_access(1'b0, `CTW_OFS_STATUS, 32'h08);
      issue(`CTW_OP_WRITE_CHAR, sel, w, 25'h0, R_SKIP);
      repeat (PC - 8) @(posedge ref_clk);
      reg_access(1'b0, `CTW_OFS_STATUS, 32'h28);
      repeat (10) @(posedge ref_clk);
      reg_access(1'b0, `CTW_OFS_STATUS, 32'h09);
      reg_access(1'b1, `CTW_OFS_CLEAR, 32'h1);
    end
    issue(`CTW_OP_ARM_KEYBOARD, 2'd0, 24'h0, 25'h0, R_NEXT);
    reg_access(1'b0, `CTW_OFS_STATUS, 32'h18);
    c = 6'($random(seed));
    i_ctw_console_model.press_key(c, 3);
    reg_access(1'b0, `CTW_OFS_BUFFER, {22'h0, c[5:4], 2'b00, c});
    reg_access(1'b0, `CTW_OFS_STATUS, 32'h09);
    ar = 25'($random(seed));
    issue(`CTW_OP_READ_CHAR, 2'd0, 24'h0, ar, '{1'b1, 2'd1, 1'b1,
          {ar[24:6], (6'(ar[4:0]) + 6'(c[4:0])) > 6'h1F ? 1'b1 : ar[5] ^ c[5], 5'(ar[4:0] + c[4:0])}});
    issue(`CTW_OP_ARM_KEYBOARD, 2'd0, 24'h0, 25'h0, R_NEXT);
    i_ctw_console_model.press_btn(0);
    i_ctw_console_model.press_btn(1);
    reg_access(1'b0, `CTW_OFS_STATUS, 32'h0F);
    reg_access(1'b1, `CTW_OFS_CLEAR, 32'h7);
    i_ctw_console_model.press_btn(2);
    reg_access(1'b0, `CTW_OFS_STATUS, 32'h00);
    issue(`CTW_OP_WRITE_CHAR, 2'd1, 24'($random(seed)), 25'h0, R_NEXT);
    c = 6'($random(seed));
    exp_type_q.push_back({1'b1, c});
    i_ctw_console_model.press_key(c, 6);
    i_ctw_console_model.press_btn(0);
    reg_access(1'b0, `CTW_OFS_STATUS, 32'h00);
    reg_access(1'b1, `CTW_OFS_MODE, 32'h1);
    reg_access(1'b0, `CTW_OFS_STATUS, 32'h08);
    reg_access(1'b0, `CTW_OFS_MODE, 32'h1);
    repeat (4) @(posedge ref_clk);
    print_verdict();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    print_verdict();
  end

endmodule : ctw_port_test

bind ctw_port ctw_port_asserts i_ctw_port_asserts (.ref_clk(ref_clk), .rst(rst), .instr(instr),
  .result(result), .type_fire(type_fire), .type_char(type_char), .kbd_active_lamp(kbd_active_lamp),
  .online_lamp(online_lamp), .contingency_irq(contingency_irq));

// ===== verilog/ctw_map.svh
`ifndef CTW_MAP_SVH
`define CTW_MAP_SVH

// ==========================================================================
// Register offsets on the software port
`define CTW_ADDR_W          4
`define CTW_DATA_W          32
`define CTW_OFS_STATUS      4'h0
`define CTW_OFS_CLEAR       4'h4
`define CTW_OFS_BUFFER      4'h8
`define CTW_OFS_MODE        4'hC

// ==========================================================================
// Status and clear field positions
`define CTW_BIT_TW_INT      0
`define CTW_BIT_KREQ        1
`define CTW_BIT_KREL        2
`define CTW_BIT_ONLINE      3
`define CTW_BIT_LAMP        4
`define CTW_BIT_BUSY        5
`define CTW_BIT_MODE_TOGGLE 0

// ==========================================================================
// Instruction opcodes (octal 02, 66, 01)
`define CTW_OP_WRITE_CHAR   6'h02
`define CTW_OP_ARM_KEYBOARD 6'h36
`define CTW_OP_READ_CHAR    6'h01

// ==========================================================================
// Character code points for format control
`define CTW_CH_CR_LF        6'h13
`define CTW_CH_BELL         6'h23
`define CTW_CH_TAB          6'h2E
`define CTW_CH_FORM_FEED    6'h3E

// ==========================================================================
// Reset values
`define CTW_RST_ONLINE      1'b1
`define CTW_RST_LAMP        1'b0
`define CTW_RST_CHAR        6'h00

// ==========================================================================
// Timing: ten characters per second on a 200 MHz clock
`define CTW_CLK_MHZ         200
`define CTW_PRINT_TIME_US   100000
`define CTW_PRINT_CYCLES    (`CTW_PRINT_TIME_US * `CTW_CLK_MHZ)

`endif

// ===== verilog/ctw_pkg.sv
package ctw_pkg;

  // ========================================================================
  // Types shared by the console typewriter port
  typedef logic [5:0] ctw_char_t;

  // Instruction presented by the processor control unit for one cycle
  typedef struct packed {
    logic        valid;     // One-cycle issue strobe
    logic [5:0]  opcode;    // Operation code
    logic [1:0]  char_sel;  // Instruction bits 11-12
    logic [23:0] mem_word;  // Indexed memory word, bits 1-24
    logic [24:0] ar_value;  // Designated arithmetic register, bits 1-25
  } ctw_instr_s;

  // Result handed back to the control unit
  typedef struct packed {
    logic        done;      // One-cycle answer strobe
    logic [1:0]  cc_step;   // Control counter increment
    logic        ar_we;     // Arithmetic register write
    logic [24:0] ar_data;   // New register value
  } ctw_result_s;

  // Print cycle state
  typedef enum logic [0:0] {
    CTW_PR_IDLE = 1'b0,
    CTW_PR_BUSY = 1'b1
  } ctw_print_e;

endpackage : ctw_pkg

// ===== verilog/ctw_port.sv
// Added by the designer: the register addresses and strobed register access.
`include "ctw_map.svh"

module ctw_port
  import ctw_pkg::*;
#(
  parameter int PRINT_CYCLES = `CTW_PRINT_CYCLES
) (
  input  wire logic                   ref_clk,
  input  wire logic                   rst,
  // Processor instruction port
  input  wire ctw_instr_s             instr,
  output ctw_result_s                 result,
  // Software register port
  input  wire logic [`CTW_ADDR_W-1:0] reg_addr,
  input  wire logic [`CTW_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`CTW_DATA_W-1:0] reg_rdata,
  // Console keyboard and buttons (asynchronous pins)
  input  wire logic                   key_press,
  input  wire logic [5:0]             key_code,
  input  wire logic                   kbd_request_btn,
  input  wire logic                   kbd_release_btn,
  input  wire logic                   online_btn,
  // Typewriter mechanism and console lamps
  output logic                        type_fire,
  output logic [5:0]                  type_char,
  output logic                        kbd_active_lamp,
  output logic                        online_lamp,
  output logic                        contingency_irq
);

  // ========================================================================
  // Helper functions

  // Select one six-bit character of a memory word
  function automatic ctw_char_t pick_char(input logic [23:0] word, input logic [1:0] sel);
    ctw_char_t c;
    c = word[5:0];
    unique case (sel)
      2'h0: c = word[5:0];
      2'h1: c = word[11:6];
      2'h2: c = word[17:12];
      2'h3: c = word[23:18];
    endcase
    return c;
  endfunction : pick_char

  // Add a character into bits 1-6 of a register, no carry beyond bit 6
  function automatic logic [24:0] add_char(input logic [24:0] ar, input ctw_char_t ch);
    logic [5:0] low;
    logic [5:0] res;
    low    = {1'b0, ar[4:0]} + {1'b0, ch[4:0]};
    res    = low;
    res[5] = low[5] ? 1'b1 : (ar[5] ^ ch[5]);
    return {ar[24:6], res};
  endfunction : add_char

  // Zone part of a character
  function automatic logic [1:0] zone_of(input ctw_char_t ch);
    return ch[5:4];
  endfunction : zone_of

  // ========================================================================
  // Pin synchronisers

  // Stable pin levels and their press edges
  logic [3:0] pin_level;
  logic [3:0] pin_rise;
  logic [5:0] code_level;

  ctw_sync #(
    .W (4)
  ) u_btn_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin_in  ({online_btn, kbd_release_btn, kbd_request_btn, key_press}),
    .level   (pin_level),
    .rise    (pin_rise)
  );

  // Key code lines take the same two stages, so code and strobe line up
  ctw_sync #(
    .W (6)
  ) u_code_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin_in  (key_code),
    .level   (code_level),
    .rise    ()
  );

  // Press events of the four console pins
  logic key_ev;
  logic req_ev;
  logic rel_ev;
  logic mode_ev;

  // Press events from the stable stage
  assign key_ev  = pin_rise[0];
  assign req_ev  = pin_rise[1];
  assign rel_ev  = pin_rise[2];
  assign mode_ev = pin_rise[3];

  // ========================================================================
  // Instruction decode

  // Decoded one-cycle instruction strobes
  logic is_write;
  logic is_arm;
  logic is_read;
  logic sw_toggle;

  assign is_write = instr.valid && (instr.opcode == `CTW_OP_WRITE_CHAR);
  assign is_arm   = instr.valid && (instr.opcode == `CTW_OP_ARM_KEYBOARD);
  assign is_read  = instr.valid && (instr.opcode == `CTW_OP_READ_CHAR);

  // ========================================================================
  // Register port decode

  // Software clear strobe and mode toggle
  logic wr_clear;
  logic [`CTW_DATA_W-1:0] clr_bits;

  assign wr_clear  = reg_wr && (reg_addr == `CTW_OFS_CLEAR);
  assign sw_toggle = reg_wr && (reg_addr == `CTW_OFS_MODE) && reg_wdata[`CTW_BIT_MODE_TOGGLE];
  assign clr_bits  = wr_clear ? reg_wdata : '0;

  // ========================================================================
  // State

  // Mode, lamp, buffer and the three indicators
  logic        online_q;
  logic        lamp_q;
  ctw_char_t   buf_q;
  logic        tw_int_q;
  logic        kreq_q;
  logic        krel_q;
  logic        print_start;
  logic        print_busy;
  logic        print_done;
  logic        key_accept;

  // Online key press accepted only while the keyboard is armed
  assign key_accept  = key_ev && online_q && lamp_q;
  assign print_start = is_write && online_q;

  // ========================================================================
  // Print cycle timer

  // A write during a running print cycle restarts it
  ctw_print_timer #(
    .CYCLES (PRINT_CYCLES)
  ) u_print_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (print_start),
    .busy    (print_busy),
    .done    (print_done)
  );

  // ========================================================================
  // Online/offline mode; console button or software toggle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      online_q <= `CTW_RST_ONLINE;
    end else if (mode_ev ^ sw_toggle) begin
      online_q <= ~online_q;
    end
  end

  // ========================================================================
  // Keyboard active lamp; arm wins over a same-cycle key or release
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lamp_q <= `CTW_RST_LAMP;
    end else if (is_arm) begin
      lamp_q <= 1'b1;
    end else if (key_accept || (rel_ev && online_q)) begin
      lamp_q <= 1'b0;
    end
  end

  // ========================================================================
  // Character buffer, shared by input and output
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      buf_q <= `CTW_RST_CHAR;
    end else if (print_start) begin
      buf_q <= pick_char(instr.mem_word, instr.char_sel);
    end else if (key_accept) begin
      buf_q <= code_level;
    end
  end

  // ========================================================================
  // Typewriter interrupt indicator; a set beats a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tw_int_q <= 1'b0;
    end else if (key_accept || (print_done && online_q)) begin
      tw_int_q <= 1'b1;
    end else if (clr_bits[`CTW_BIT_TW_INT]) begin
      tw_int_q <= 1'b0;
    end
  end

  // ========================================================================
  // Keyboard request indicator
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      kreq_q <= 1'b0;
    end else if (req_ev && online_q) begin
      kreq_q <= 1'b1;
    end else if (clr_bits[`CTW_BIT_KREQ]) begin
      kreq_q <= 1'b0;
    end
  end

  // ========================================================================
  // Keyboard release indicator
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      krel_q <= 1'b0;
    end else if (rel_ev && online_q) begin
      krel_q <= 1'b1;
    end else if (clr_bits[`CTW_BIT_KREL]) begin
      krel_q <= 1'b0;
    end
  end

  // ========================================================================
  // Answer to the control unit, one cycle after the instruction
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      result <= '0;
    end else begin
      result.done    <= is_write || is_arm || is_read;
      result.ar_we   <= is_read;
      result.ar_data <= is_read ? add_char(instr.ar_value, buf_q) : '0;
      if (is_write) begin
        result.cc_step <= online_q ? 2'h2 : 2'h1;
      end else if (is_arm || is_read) begin
        result.cc_step <= 2'h1;
      end else begin
        result.cc_step <= 2'h0;
      end
    end
  end

  // ========================================================================
  // Drive to the typewriter mechanism
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      type_fire <= 1'b0;
      type_char <= `CTW_RST_CHAR;
    end else if (print_start) begin
      type_fire <= 1'b1;
      type_char <= pick_char(instr.mem_word, instr.char_sel);
    end else if (key_ev && !online_q) begin
      type_fire <= 1'b1;
      type_char <= code_level;
    end else begin
      type_fire <= 1'b0;
    end
  end

  // ========================================================================
  // Lamps and contingency request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      kbd_active_lamp <= `CTW_RST_LAMP;
      online_lamp     <= `CTW_RST_ONLINE;
      contingency_irq <= 1'b0;
    end else begin
      kbd_active_lamp <= lamp_q;
      online_lamp     <= online_q;
      contingency_irq <= tw_int_q | kreq_q | krel_q;
    end
  end

  // ========================================================================
  // Register read data, valid in the cycle after the read strobe
  logic [`CTW_DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    unique case (reg_addr)
      `CTW_OFS_STATUS: begin
        rd_mux[`CTW_BIT_TW_INT] = tw_int_q;
        rd_mux[`CTW_BIT_KREQ]   = kreq_q;
        rd_mux[`CTW_BIT_KREL]   = krel_q;
        rd_mux[`CTW_BIT_ONLINE] = online_q;
        rd_mux[`CTW_BIT_LAMP]   = lamp_q;
        rd_mux[`CTW_BIT_BUSY]   = print_busy;
      end
      `CTW_OFS_BUFFER: begin
        rd_mux[5:0] = buf_q;
        rd_mux[9:8] = zone_of(buf_q);
      end
      `CTW_OFS_MODE: begin
        rd_mux[`CTW_BIT_MODE_TOGGLE] = online_q;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

endmodule : ctw_port

// ===== verilog/ctw_print_timer.sv
module ctw_print_timer
  import ctw_pkg::*;
#(
  parameter int CYCLES = 20000000
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  localparam int CW = $clog2(CYCLES + 1);

  ctw_print_e    state_q;
  logic [CW-1:0] count_q;
  logic          done_q;

  // ========================================================================
  // One print cycle lasts CYCLES clocks; a new start restarts it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= CTW_PR_IDLE;
      count_q <= '0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        state_q <= CTW_PR_BUSY;
        count_q <= CW'(CYCLES - 1);
      end else begin
        unique case (state_q)
          CTW_PR_IDLE: begin
            count_q <= '0;
          end
          CTW_PR_BUSY: begin
            if (count_q == '0) begin
              state_q <= CTW_PR_IDLE;
              done_q  <= 1'b1;
            end else begin
              count_q <= count_q - CW'(1);
            end
          end
        endcase
      end
    end
  end

  assign busy = (state_q == CTW_PR_BUSY);
  assign done = done_q;

endmodule : ctw_print_timer

// ===== verilog/ctw_sync.sv
module ctw_sync
  import ctw_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  logic [W-1:0] meta_q;
  logic [W-1:0] stab_q;
  logic [W-1:0] prev_q;

  // ========================================================================
  // Two-stage synchroniser; only the second stage feeds logic
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_q <= '0;
      stab_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pin_in;
      stab_q <= meta_q;
      prev_q <= stab_q;
    end
  end

  // Level and press edge taken from the stable stage
  assign level = stab_q;
  assign rise  = stab_q & ~prev_q;

endmodule : ctw_sync
